// >>> include/epd_pkg.sv
package epd_pkg;
	// Command codes
	localparam logic [7:0] CMD_GATE_OUTPUT = 8'h01;
	localparam logic [7:0] CMD_GATE_VOLT = 8'h03;
	localparam logic [7:0] CMD_SOURCE_VOLT = 8'h04;
	localparam logic [7:0] CMD_SCAN_START = 8'h0F;
	localparam logic [7:0] CMD_SLEEP = 8'h10;
	localparam logic [7:0] CMD_ENTRY_MODE = 8'h11;
	localparam logic [7:0] CMD_SOFT_RESTART = 8'h12;
	localparam logic [7:0] CMD_LEVEL_CHECK = 8'h14;
	localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
	localparam logic [7:0] CMD_SENSOR_SELECT = 8'h18;
	localparam logic [7:0] CMD_TEMP_WRITE = 8'h1A;
	localparam logic [7:0] CMD_TEMP_READ = 8'h1B;
	localparam logic [7:0] CMD_UPDATE_CTRL = 8'h22;
	localparam logic [7:0] CMD_STATUS_READ = 8'h2F;
	// Reset values
	localparam logic [9:0] RST_LINE_COUNT = 10'h000;
	localparam logic [2:0] RST_GATE_MODE = 3'h0;
	localparam logic [4:0] RST_GATE_VOLT = 5'h00;
	localparam logic [7:0] RST_SRC_A = 8'h41;
	localparam logic [7:0] RST_SRC_B = 8'hA8;
	localparam logic [7:0] RST_SRC_NEG = 8'h32;
	localparam logic [9:0] RST_SCAN_START = 10'h000;
	localparam logic [1:0] RST_SLEEP = 2'h0;
	localparam logic [2:0] RST_ENTRY = 3'h3;
	localparam logic [2:0] RST_SUPPLY_LEVEL = 3'h4;
	localparam logic [7:0] RST_SENSOR = 8'h48;
	localparam logic [11:0] RST_TEMP = 12'h7FF;
	localparam logic [7:0] RST_UPDATE_CTRL = 8'hFF;
	// Field positions
	localparam int GATE_PICK_BIT = 0;
	localparam int GATE_SPLIT_BIT = 1;
	localparam int ADVANCE_AXIS_BIT = 2;
	localparam int CLOCK_ENABLE_FLAG_BIT = 7;
	localparam int ANALOG_ENABLE_FLAG_BIT = 6;
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int RESTART_NS = 2000;
	localparam int RESTART_CYC = RESTART_NS * CLK_MHZ / 1000;
	localparam int DETECT_NS = 4000;
	localparam int DETECT_CYC = DETECT_NS * CLK_MHZ / 1000;
	localparam int TIMER_W = 16;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RESTART = 2'b01,
		ST_DETECT = 2'b10,
		ST_SLEEP = 2'b11
	} epd_state_type;
endpackage

// >>> include/epd_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
// Bytes from the link domain and the reply byte back to it
interface epd_byte_if;
	logic [7:0] rx_byte;
	logic rx_is_data;
	logic rx_toggle;
	logic [7:0] tx_byte;
	modport link (output rx_byte, rx_is_data, rx_toggle, input tx_byte);
	modport core (input rx_byte, rx_is_data, rx_toggle, output tx_byte);
endinterface
`default_nettype wire

// >>> rtl/epd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser
module epd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First flop feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/epd_link.sv
`timescale 1ns/1ps
`default_nettype none
// Serial link front end, runs on the serial clock
module epd_link (
	// Link clock and async clear
	input wire logic sclk,
	input wire logic rst,
	// Pins
	input wire logic cs_n,
	input wire logic dc,
	input wire logic serial_in_line,
	input wire logic link_width_select,
	output logic serial_out_line,
	output logic serial_out_oe,
	// Core side
	epd_byte_if.link bus
);
	logic [8:0] shift_q;
	logic [3:0] cnt_q;
	logic [7:0] out_q;
	logic [2:0] ocnt_q;
	logic data_phase_q;
	logic clr;
	logic [3:0] need;

	assign clr = rst | cs_n;
	assign need = link_width_select ? 4'h8 : 4'h7;

	// Shift in on rising edge, msb first; deselect drops a partial byte
	always_ff @(posedge sclk or posedge clr) begin
		if (clr) begin
			shift_q <= '0;
			cnt_q <= '0;
			data_phase_q <= 1'b0;
		end else begin
			shift_q <= {shift_q[7:0], serial_in_line};
			if (cnt_q == need) begin
				cnt_q <= '0;
				data_phase_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// Finished byte, cleared only by reset so a deselect cannot fake a toggle
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			bus.rx_byte <= '0;
			bus.rx_is_data <= 1'b0;
			bus.rx_toggle <= 1'b0;
		end else if (cnt_q == need) begin
			bus.rx_byte <= {shift_q[6:0], serial_in_line};
			// Select bit leads in three-wire mode, pin level otherwise
			bus.rx_is_data <= link_width_select ? shift_q[7] : dc;
			bus.rx_toggle <= ~bus.rx_toggle;
		end
	end

	// Shift out on falling edge, msb first
	always_ff @(negedge sclk or posedge clr) begin
		if (clr) begin
			out_q <= '0;
			ocnt_q <= '0;
			serial_out_line <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (data_phase_q && (cnt_q != need || !link_width_select)) begin
			serial_out_oe <= 1'b1;
			if (ocnt_q == 3'h0) begin
				serial_out_line <= bus.tx_byte[7];
				out_q <= {bus.tx_byte[6:0], 1'b0};
			end else begin
				serial_out_line <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
			ocnt_q <= ocnt_q + 3'h1;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/epd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - first_gate_pick chooses G0 or G1 first
// - gate_order_split selects sequential or even-odd order
// - gate voltage five-bit code, reset zero
// - three source level bytes with defaults
// - scan start ten bits, low byte first
// - sleep field 00 normal, 01/11 sleep
// - busy held high while sleeping
// - address_step_direction sets per-axis direction
// - address_advance_axis picks X or Y advance
// - soft restart resets settings except sleep
// - soft restart leaves display memory untouched
// - level check sets busy, then status readable
// - supply detect level three bits, default 100
// - supply detect sets busy, then status readable
// - sensor select 48h external, 80h internal
// - temperature write packs twelve bits in two
// - temperature read returns same packing
// - four-wire shifts msb first, select steady
// - three-wire leading bit picks command/data
// - read bytes shifted out on falling edges
module epd_decoder (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dc,
	input wire logic serial_in_line,
	input wire logic link_width_select,
	output logic serial_out_line,
	output logic serial_out_oe,
	// Detector results from analog side
	input wire logic drive_level_ok,
	input wire logic supply_ok,
	// Status
	output logic busy,
	// Settings
	output logic [9:0] gate_lines,
	output logic first_gate_pick,
	output logic gate_order_split,
	output logic scan_reverse,
	output logic [4:0] gate_volt_code,
	output logic [7:0] positive_source_level_a,
	output logic [7:0] positive_source_level_b,
	output logic [7:0] negative_source_level,
	output logic [9:0] scan_start,
	output logic [1:0] sleep_mode,
	output logic [1:0] address_step_direction,
	output logic address_advance_axis,
	output logic [2:0] supply_level_code,
	output logic [7:0] sensor_sel,
	output logic [11:0] temperature,
	output logic clock_enable_flag,
	output logic analog_enable_flag
);
	// ----------------------------------------------------------------
	// Link domain and crossings
	// ----------------------------------------------------------------
	epd_byte_if bif ();
	logic link_rst;
	logic [1:0] link_rst_q;
	logic tog_s, tog_q;
	logic [1:0] ok_s;
	logic new_byte;
	logic [7:0] rx_b;
	logic rx_data;
	logic [7:0] tx_q;

	// Reset held into the link domain until the second clk edge after reset releases it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_rst_q <= 2'b11;
		end else begin
			link_rst_q <= {link_rst_q[0], 1'b0};
		end
	end
	assign link_rst = link_rst_q[1];

	epd_link u_link (
		.sclk(sclk),
		.rst(link_rst),
		.cs_n(cs_n),
		.dc(dc),
		.serial_in_line(serial_in_line),
		.link_width_select(link_width_select),
		.serial_out_line(serial_out_line),
		.serial_out_oe(serial_out_oe),
		.bus(bif.link)
	);

	epd_sync #(.W(1)) u_tog (
		.clk(clk),
		.rst(rst),
		.d(bif.rx_toggle),
		.q(tog_s)
	);

	epd_sync #(.W(2)) u_ok (
		.clk(clk),
		.rst(rst),
		.d({drive_level_ok, supply_ok}),
		.q(ok_s)
	);

	// Toggle edge marks a byte; the byte has been stable since
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= tog_s;
		end
	end
	assign new_byte = tog_s ^ tog_q;
	assign rx_b = bif.rx_byte;
	assign rx_data = bif.rx_is_data;
	assign bif.tx_byte = tx_q;

	// ----------------------------------------------------------------
	// Command tracking
	// ----------------------------------------------------------------
	logic [7:0] cmd_q;
	logic [1:0] idx_q;
	logic [11:0] temp_q;
	logic status_level_q, status_supply_q;
	epd_pkg::epd_state_type state_q;
	logic [epd_pkg::TIMER_W-1:0] timer_q;
	logic accept;
	logic restart_go;

	// Commands are ignored while sleeping or busy
	assign accept = new_byte && (state_q == epd_pkg::ST_IDLE);
	assign restart_go = accept && !rx_data && rx_b == epd_pkg::CMD_SOFT_RESTART;

	// Current command and parameter index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_q <= 8'h00;
			idx_q <= 2'h0;
		end else if (accept && !rx_data) begin
			cmd_q <= rx_b;
			idx_q <= 2'h0;
		end else if (accept && idx_q != 2'h3) begin
			idx_q <= idx_q + 2'h1;
		end
	end

	// Reply byte for reads, packing as the write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_q <= 8'h00;
		end else if (cmd_q == epd_pkg::CMD_TEMP_READ) begin
			tx_q <= (idx_q == 2'h0) ? temp_q[11:4] : {temp_q[3:0], 4'h0};
		end else if (cmd_q == epd_pkg::CMD_STATUS_READ) begin
			tx_q <= {2'b00, status_level_q, status_supply_q, 4'h0};
		end else begin
			tx_q <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Setting registers
	// ----------------------------------------------------------------
	logic [9:0] lines_q;
	logic [2:0] gmode_q;
	logic [4:0] gvolt_q;
	logic [7:0] sa_q, sb_q, sn_q;
	logic [9:0] start_q;
	logic [1:0] sleep_q;
	logic [2:0] entry_q;
	logic [2:0] supply_q;
	logic [7:0] sensor_q;
	logic [7:0] upd_q;
	logic wr;

	assign wr = accept && rx_data;

	// Settings return to defaults on soft restart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lines_q <= epd_pkg::RST_LINE_COUNT;
			gmode_q <= epd_pkg::RST_GATE_MODE;
			gvolt_q <= epd_pkg::RST_GATE_VOLT;
			sa_q <= epd_pkg::RST_SRC_A;
			sb_q <= epd_pkg::RST_SRC_B;
			sn_q <= epd_pkg::RST_SRC_NEG;
			start_q <= epd_pkg::RST_SCAN_START;
			entry_q <= epd_pkg::RST_ENTRY;
			supply_q <= epd_pkg::RST_SUPPLY_LEVEL;
			sensor_q <= epd_pkg::RST_SENSOR;
			temp_q <= epd_pkg::RST_TEMP;
			upd_q <= epd_pkg::RST_UPDATE_CTRL;
		end else if (restart_go) begin
			lines_q <= epd_pkg::RST_LINE_COUNT;
			gmode_q <= epd_pkg::RST_GATE_MODE;
			gvolt_q <= epd_pkg::RST_GATE_VOLT;
			sa_q <= epd_pkg::RST_SRC_A;
			sb_q <= epd_pkg::RST_SRC_B;
			sn_q <= epd_pkg::RST_SRC_NEG;
			start_q <= epd_pkg::RST_SCAN_START;
			entry_q <= epd_pkg::RST_ENTRY;
			supply_q <= epd_pkg::RST_SUPPLY_LEVEL;
			sensor_q <= epd_pkg::RST_SENSOR;
			temp_q <= epd_pkg::RST_TEMP;
			upd_q <= epd_pkg::RST_UPDATE_CTRL;
		end else if (wr) begin
			case (cmd_q)
				epd_pkg::CMD_GATE_OUTPUT: begin
					if (idx_q == 2'h0) lines_q[7:0] <= rx_b;
					else if (idx_q == 2'h1) lines_q[9:8] <= rx_b[1:0];
					else if (idx_q == 2'h2) gmode_q <= rx_b[2:0];
				end
				epd_pkg::CMD_GATE_VOLT: if (idx_q == 2'h0) gvolt_q <= rx_b[4:0];
				epd_pkg::CMD_SOURCE_VOLT: begin
					if (idx_q == 2'h0) sa_q <= rx_b;
					else if (idx_q == 2'h1) sb_q <= rx_b;
					else if (idx_q == 2'h2) sn_q <= rx_b;
				end
				epd_pkg::CMD_SCAN_START: begin
					if (idx_q == 2'h0) start_q[7:0] <= rx_b;
					else if (idx_q == 2'h1) start_q[9:8] <= rx_b[1:0];
				end
				epd_pkg::CMD_ENTRY_MODE: if (idx_q == 2'h0) entry_q <= rx_b[2:0];
				epd_pkg::CMD_SUPPLY_DETECT: if (idx_q == 2'h0) supply_q <= rx_b[2:0];
				epd_pkg::CMD_SENSOR_SELECT: if (idx_q == 2'h0) sensor_q <= rx_b;
				epd_pkg::CMD_TEMP_WRITE: begin
					if (idx_q == 2'h0) temp_q[11:4] <= rx_b;
					else if (idx_q == 2'h1) temp_q[3:0] <= rx_b[7:4];
				end
				epd_pkg::CMD_UPDATE_CTRL: if (idx_q == 2'h0) upd_q <= rx_b;
				default: begin
				end
			endcase
		end
	end

	// Sleep setting survives soft restart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_q <= epd_pkg::RST_SLEEP;
		end else if (wr && cmd_q == epd_pkg::CMD_SLEEP && idx_q == 2'h0) begin
			sleep_q <= rx_b[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Busy sequencer
	// ----------------------------------------------------------------
	logic level_go, supply_go;
	assign level_go = accept && !rx_data && rx_b == epd_pkg::CMD_LEVEL_CHECK;
	// Supply detection starts on the level parameter byte
	assign supply_go = wr && cmd_q == epd_pkg::CMD_SUPPLY_DETECT && idx_q == 2'h0;

	// Restart, detection timing and sleep entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= epd_pkg::ST_IDLE;
			timer_q <= '0;
		end else begin
			case (state_q)
				epd_pkg::ST_IDLE: begin
					if (restart_go) begin
						state_q <= epd_pkg::ST_RESTART;
						timer_q <= epd_pkg::TIMER_W'(epd_pkg::RESTART_CYC - 1);
					end else if (level_go || supply_go) begin
						state_q <= epd_pkg::ST_DETECT;
						timer_q <= epd_pkg::TIMER_W'(epd_pkg::DETECT_CYC - 1);
					end else if (wr && cmd_q == epd_pkg::CMD_SLEEP && idx_q == 2'h0
						&& rx_b[0]) begin
						state_q <= epd_pkg::ST_SLEEP;
					end
				end
				epd_pkg::ST_RESTART, epd_pkg::ST_DETECT: begin
					if (timer_q == '0) state_q <= epd_pkg::ST_IDLE;
					else timer_q <= timer_q - 1'b1;
				end
				epd_pkg::ST_SLEEP: state_q <= epd_pkg::ST_SLEEP;
				default: state_q <= epd_pkg::ST_IDLE;
			endcase
		end
	end

	// Detection results latched at the end of the busy period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_level_q <= 1'b0;
			status_supply_q <= 1'b0;
		end else if (state_q == epd_pkg::ST_DETECT && timer_q == '0) begin
			if (cmd_q == epd_pkg::CMD_LEVEL_CHECK) status_level_q <= ok_s[1];
			else status_supply_q <= ok_s[0];
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			gate_lines <= '0;
			first_gate_pick <= 1'b0;
			gate_order_split <= 1'b0;
			scan_reverse <= 1'b0;
			gate_volt_code <= epd_pkg::RST_GATE_VOLT;
			positive_source_level_a <= epd_pkg::RST_SRC_A;
			positive_source_level_b <= epd_pkg::RST_SRC_B;
			negative_source_level <= epd_pkg::RST_SRC_NEG;
			scan_start <= epd_pkg::RST_SCAN_START;
			sleep_mode <= epd_pkg::RST_SLEEP;
			address_step_direction <= epd_pkg::RST_ENTRY[1:0];
			address_advance_axis <= 1'b0;
			supply_level_code <= epd_pkg::RST_SUPPLY_LEVEL;
			sensor_sel <= epd_pkg::RST_SENSOR;
			temperature <= epd_pkg::RST_TEMP;
			clock_enable_flag <= 1'b1;
			analog_enable_flag <= 1'b1;
		end else begin
			busy <= (state_q != epd_pkg::ST_IDLE);
			gate_lines <= lines_q; // count minus one, outside adds one
			first_gate_pick <= gmode_q[epd_pkg::GATE_PICK_BIT];
			gate_order_split <= gmode_q[epd_pkg::GATE_SPLIT_BIT];
			scan_reverse <= gmode_q[2];
			gate_volt_code <= gvolt_q;
			positive_source_level_a <= sa_q;
			positive_source_level_b <= sb_q;
			negative_source_level <= sn_q;
			scan_start <= start_q;
			sleep_mode <= sleep_q;
			address_step_direction <= entry_q[1:0];
			address_advance_axis <= entry_q[epd_pkg::ADVANCE_AXIS_BIT];
			supply_level_code <= supply_q;
			sensor_sel <= sensor_q;
			temperature <= temp_q;
			clock_enable_flag <= upd_q[epd_pkg::CLOCK_ENABLE_FLAG_BIT];
			analog_enable_flag <= upd_q[epd_pkg::ANALOG_ENABLE_FLAG_BIT];
		end
	end
endmodule
`default_nettype wire

// >>> sim/epd_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Timing and value checks on the decoder's ports
module epd_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched outputs
	input wire logic busy,
	input wire logic [1:0] sleep_mode,
	input wire logic [4:0] gate_volt_code,
	input wire logic [11:0] temperature,
	input wire logic [7:0] sensor_sel,
	input wire logic [1:0] address_step_direction,
	input wire logic [2:0] supply_level_code,
	input wire logic clock_enable_flag,
	input wire logic analog_enable_flag
);
	logic [15:0] busy_len_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Length of the current busy stretch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_len_q <= 16'h0000;
		end else begin
			busy_len_q <= busy ? busy_len_q + 16'h0001 : 16'h0000;
		end
	end
	a_sleep_busy: assert property (sleep_mode[0] |-> ##[0:1] busy)
		else $error("busy low while sleeping");
	a_sleep_held: assert property (sleep_mode[0] |=> $stable(sleep_mode))
		else $error("sleep mode left without reset");
	a_sleep_frozen: assert property ((sleep_mode[0] && $past(sleep_mode[0])) |->
		$stable(gate_volt_code) && $stable(temperature) && $stable(sensor_sel))
		else $error("setting changed while sleeping");
	a_busy_len_ok: assert property ($fell(busy) |-> busy_len_q inside
		{[epd_pkg::RESTART_CYC-2:epd_pkg::RESTART_CYC+2],
		[epd_pkg::DETECT_CYC-2:epd_pkg::DETECT_CYC+2]})
		else $error("busy stretch of wrong length");
	a_busy_len_cap: assert property (!sleep_mode[0] |-> busy_len_q <= 16'h00CD)
		else $error("busy stuck high outside sleep");
	a_restart_dflt: assert property (($fell(busy) && busy_len_q < 16'h0096) |->
		sensor_sel == epd_pkg::RST_SENSOR && temperature == epd_pkg::RST_TEMP &&
		gate_volt_code == epd_pkg::RST_GATE_VOLT && address_step_direction == 2'h3)
		else $error("settings not restored by restart");
	a_reset_dflt: assert property ($past(rst) |-> !busy && temperature == 12'h7FF &&
		clock_enable_flag && analog_enable_flag && supply_level_code == 3'h4)
		else $error("wrong value after reset");
	a_supply_detect: assert property ($changed(supply_level_code) |-> ##[0:2] busy)
		else $error("supply detection did not start");
endmodule
bind epd_decoder epd_checker chk_i (.clk, .rst, .busy, .sleep_mode, .gate_volt_code,
	.temperature, .sensor_sel, .address_step_direction, .supply_level_code,
	.clock_enable_flag, .analog_enable_flag);
`default_nettype wire

// >>> sim/epd_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host microcontroller model on the serial link
module epd_host (
	// Frame timing reference
	input wire logic clk,
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic dc,
	output logic serial_in_line,
	input wire logic serial_out_line,
	input wire logic serial_out_oe
);
	int half_ns = 40;
	logic oe_seen;
	// Link idles with clock still and chip deselected
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dc = 1'b0;
		serial_in_line = 1'b0;
	end
	// One bit: device samples on the rising edge, reply taken there too
	task automatic bit_x(input logic b, output logic s);
		serial_in_line = b;
		#(half_ns) sclk = 1'b1;
		s = serial_out_line;
		#(half_ns) sclk = 1'b0;
	endtask
	// Frame: select bit in three-wire mode, byte msb first, then reply bytes
	task automatic xfer(input logic is_d, input logic [7:0] v, input logic tw, input int n,
		output logic [15:0] r);
		logic s;
		r = 16'h0000;
		@(posedge clk);
		#2 cs_n = 1'b0;
		dc = is_d & ~tw;
		if (tw) bit_x(is_d, s);
		for (int i = 7; i >= 0; i--) bit_x(v[i], s);
		if (n > 0) dc = 1'b1;
		for (int i = 15; i > 15 - 8 * n; i--) begin
			bit_x(~serial_in_line, s);
			r[i] = s;
		end
		if (n > 0) oe_seen = serial_out_oe;
		#(half_ns) cs_n = 1'b1;
		serial_in_line = ~serial_in_line;
		repeat (10) @(posedge clk);
		#2;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_epaper_driver_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the command decoder
module tb_epaper_driver_command_decoder;
	logic clk, rst, sclk, cs_n, dc, serial_in_line, link_width_select;
	logic drive_level_ok, supply_ok, serial_out_line, serial_out_oe, busy;
	logic first_gate_pick, gate_order_split, scan_reverse, address_advance_axis;
	logic clock_enable_flag, analog_enable_flag;
	logic [9:0] gate_lines, scan_start;
	logic [4:0] gate_volt_code;
	logic [7:0] positive_source_level_a, positive_source_level_b;
	logic [7:0] negative_source_level, sensor_sel;
	logic [1:0] sleep_mode, address_step_direction;
	logic [2:0] supply_level_code;
	logic [11:0] temperature;
	logic [15:0] r;
	logic tw = 1'b0;
	int fail_count = 0;
	int total_checks = 0;
	// Device and host
	epd_decoder DUT (.clk, .rst, .sclk, .cs_n, .dc, .serial_in_line, .link_width_select,
		.serial_out_line, .serial_out_oe, .drive_level_ok, .supply_ok, .busy, .gate_lines,
		.first_gate_pick, .gate_order_split, .scan_reverse, .gate_volt_code,
		.positive_source_level_a, .positive_source_level_b, .negative_source_level,
		.scan_start, .sleep_mode, .address_step_direction, .address_advance_axis,
		.supply_level_code, .sensor_sel, .temperature, .clock_enable_flag, .analog_enable_flag);
	epd_host host (.clk, .sclk, .cs_n, .dc, .serial_in_line, .serial_out_line, .serial_out_oe);
	// System clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Value comparison
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for busy to drop
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (k == 400) begin
			fail_count++;
			$display("BAD %0t busy stuck", $time);
			wrap_up();
		end
	endtask
	// Command byte then n parameter bytes from the top of p
	task automatic wr(input logic [7:0] c, input int n, input logic [23:0] p);
		host.xfer(1'b0, c, tw, 0, r);
		for (int i = 0; i < n; i++) host.xfer(1'b1, p[23-8*i -: 8], tw, 0, r);
	endtask
	// Command byte then n reply bytes at the slow read rate
	task automatic rd(input logic [7:0] c, input int n);
		host.half_ns = 200;
		host.xfer(1'b0, c, 1'b0, n, r);
		host.half_ns = 40;
	endtask
	// Hardware reset pulse
	task automatic hw_reset(input int n);
		@(posedge clk);
		#2 rst = 1'b1;
		repeat (n) @(posedge clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Power-on values
	task automatic t_defaults();
		chk(gate_volt_code, 24'h0);
		chk({positive_source_level_a, positive_source_level_b}, 24'h41A8);
		chk({address_advance_axis, address_step_direction}, 24'h3);
		chk(supply_level_code, 24'h4);
		chk(sensor_sel, 24'h48);
		chk(temperature, 24'h7FF);
		chk({sleep_mode, busy}, 24'h0);
		$display("test defaults done");
	endtask
	// Gate, voltage and scan settings
	task automatic t_gate();
		wr(epd_pkg::CMD_GATE_OUTPUT, 3, 24'hA70203);
		chk(gate_lines, 24'h2A7);
		chk({first_gate_pick, gate_order_split, scan_reverse}, 24'h6);
		wr(epd_pkg::CMD_GATE_OUTPUT, 3, 24'h050100);
		chk({gate_lines, first_gate_pick, gate_order_split}, 24'h414);
		wr(epd_pkg::CMD_GATE_VOLT, 1, 24'h170000);
		chk(gate_volt_code, 24'h17);
		wr(epd_pkg::CMD_SOURCE_VOLT, 3, 24'h4B8E3A);
		chk({positive_source_level_a, positive_source_level_b}, 24'h4B8E);
		chk(negative_source_level, 24'h3A);
		wr(epd_pkg::CMD_SCAN_START, 2, 24'h340200);
		chk(scan_start, 24'h234);
		for (int v = 0; v < 8; v++) begin
			wr(epd_pkg::CMD_ENTRY_MODE, 1, {v[7:0], 16'h0000});
			chk({address_advance_axis, address_step_direction}, v);
		end
		$display("test settings done");
	endtask
	// Temperature, sensor and three-wire writes
	task automatic t_temp();
		wr(epd_pkg::CMD_TEMP_WRITE, 2, 24'hABC000);
		chk(temperature, 24'hABC);
		rd(epd_pkg::CMD_TEMP_READ, 2);
		chk(r, 24'hABC0);
		chk({host.oe_seen, serial_out_oe}, 24'h2);
		wr(epd_pkg::CMD_SENSOR_SELECT, 1, 24'h800000);
		chk(sensor_sel, 24'h80);
		tw = 1'b1;
		link_width_select = 1'b1;
		wr(epd_pkg::CMD_GATE_VOLT, 1, 24'h0B0000);
		chk(gate_volt_code, 24'h0B);
		tw = 1'b0;
		link_width_select = 1'b0;
		$display("test temperature done");
	endtask
	// Level check and supply detection with status reads
	task automatic t_detect();
		logic [2:0] codes[5] = '{3'h3, 3'h5, 3'h6, 3'h7, 3'h4};
		wr(epd_pkg::CMD_UPDATE_CTRL, 1, 24'hC00000);
		chk({clock_enable_flag, analog_enable_flag}, 24'h3);
		drive_level_ok = 1'b1;
		wr(epd_pkg::CMD_LEVEL_CHECK, 0, 24'h0);
		chk(busy, 24'h1);
		wait_idle();
		rd(epd_pkg::CMD_STATUS_READ, 1);
		chk(r[15:8], 24'h20);
		supply_ok = 1'b1;
		foreach (codes[i]) begin
			wr(epd_pkg::CMD_SUPPLY_DETECT, 1, {5'h00, codes[i], 16'h0000});
			chk({busy, supply_level_code}, {20'h0, 1'b1, codes[i]});
			wait_idle();
		end
		rd(epd_pkg::CMD_STATUS_READ, 1);
		chk(r[15:8], 24'h30);
		$display("test detect done");
	endtask
	// Soft restart refuses bytes and restores defaults
	task automatic t_restart();
		wr(epd_pkg::CMD_ENTRY_MODE, 1, 24'h000000);
		wr(epd_pkg::CMD_SOFT_RESTART, 0, 24'h0);
		chk(busy, 24'h1);
		wr(epd_pkg::CMD_GATE_VOLT, 1, 24'h090000);
		wait_idle();
		chk({sensor_sel, gate_volt_code}, 24'h000900);
		chk({sleep_mode, address_advance_axis, address_step_direction}, 24'h3);
		$display("test restart done");
	endtask
	// Both sleep modes, refusal, and exit by hardware reset
	task automatic t_sleep();
		for (int m = 1; m < 4; m += 2) begin
			wr(epd_pkg::CMD_SLEEP, 1, {m[7:0], 16'h0000});
			chk({sleep_mode, busy}, {m[1:0], 1'b1});
			wr(epd_pkg::CMD_GATE_VOLT, 1, 24'h050000);
			chk({busy, gate_volt_code}, 24'h20);
			hw_reset(2);
			chk({sleep_mode, busy}, 24'h0);
		end
		$display("test sleep done");
	endtask
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		$display("BAD %0t run limit reached", $time);
		wrap_up();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		link_width_select = 1'b0;
		drive_level_ok = 1'b0;
		supply_ok = 1'b0;
		hw_reset(16);
		t_defaults();
		t_gate();
		t_temp();
		t_detect();
		t_restart();
		t_sleep();
		wrap_up();
	end
endmodule
`default_nettype wire
